// file: wdt_pkg.sv
// Constants shared by the watchdog timeout timer files
package wdt_pkg;

	// ==========================================================
	// Register map (printed offsets are word indices)
	localparam logic [7:0] CTRL_IDX = 8'hAA;
	localparam logic [7:0] KEY_IDX = 8'hB0;
	localparam logic [7:0] MODE_IDX = 8'hB1;
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] CTRL_ADDR = ADDR_W'({CTRL_IDX, 2'b00});
	localparam logic [ADDR_W-1:0] KEY_ADDR = ADDR_W'({KEY_IDX, 2'b00});
	localparam logic [ADDR_W-1:0] MODE_ADDR = ADDR_W'({MODE_IDX, 2'b00});

	// ==========================================================
	// Control register fields
	localparam int RUN_BIT = 7;
	localparam int CLR_BIT = 6;
	localparam int FLAG_BIT = 5;
	localparam int LPRUN_BIT = 4;
	localparam int CAUSE_BIT = 3;
	localparam int PSEL_MSB = 2;
	localparam logic [2:0] PRESCALE_RESET = 3'h7;

	// ==========================================================
	// Factory option byte: mode field in bits 7:4
	localparam int MODE_MSB = 7;
	localparam int MODE_LSB = 4;
	localparam logic [3:0] MODE_GP = 4'hF;
	localparam logic [3:0] MODE_STOP_LP = 4'h5;
	localparam logic [7:0] FACTORY_RESET = 8'hFF;

	// ==========================================================
	// Timed access key sequence
	localparam logic [7:0] KEY_FIRST = 8'hAA;
	localparam logic [7:0] KEY_SECOND = 8'h55;

	// ==========================================================
	// Timing
	localparam int CLK_HZ = 200000000;
	localparam int SLOW_OSC_HZ = 10000;
	localparam int SLOW_OSC_DIV = CLK_HZ / SLOW_OSC_HZ;
	localparam int TIMEOUT_TICKS = 64;
	localparam int RESET_DELAY_TICKS = 512;

	// ==========================================================
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_OPEN} key_state_type;

endpackage

// file: wdt_prescaler.sv
// Slow oscillator tick source and watchdog clock prescaler
`timescale 1ns/1ps
module wdt_prescaler #(
	parameter int SLOW_DIV = wdt_pkg::SLOW_OSC_DIV
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clear,
	input wire logic enable,
	input wire logic [2:0] sel,
	output logic slow_tick,
	output logic scaled_tick
);
	import wdt_pkg::*;

	logic [15:0] osc_cnt_q;
	logic [7:0] pre_cnt_q;
	logic [7:0] limit;

	// Free running slow oscillator stand-in, one tick per period
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_cnt_q <= 16'h0000;
			slow_tick <= 1'b0;
		end else if (osc_cnt_q == 16'(SLOW_DIV - 1)) begin
			osc_cnt_q <= 16'h0000;
			slow_tick <= 1'b1;
		end else begin
			osc_cnt_q <= osc_cnt_q + 16'h0001;
			slow_tick <= 1'b0;
		end
	end

	// Divide ratio: 1, then 4 through 256 by powers of two
	always_comb begin
		limit = (sel == 3'h0) ? 8'h00 : 8'((9'h001 << ({1'b0, sel} + 4'h1)) - 9'h001);
	end

	// Prescale counter, cleared with the main counter
	always_ff @(posedge aclk) begin
		if (!aresetn || clear) begin
			pre_cnt_q <= 8'h00;
			scaled_tick <= 1'b0;
		end else if (enable && slow_tick) begin
			if (pre_cnt_q == limit) begin
				pre_cnt_q <= 8'h00;
				scaled_tick <= 1'b1;
			end else begin
				pre_cnt_q <= pre_cnt_q + 8'h01;
				scaled_tick <= 1'b0;
			end
		end else begin
			scaled_tick <= 1'b0;
		end
	end

endmodule // wdt_prescaler

// file: watchdog_timeout_timer.sv
// Watchdog timeout timer with AXI4-Lite control register access
//
// Overview of operation
// - Mode field all ones: general-purpose timer run by software, no reset.
// - Mode 0101: reset watchdog, counting halted in Idle or Power-down.
// - Any other mode: reset watchdog that keeps counting in low power.
// - Counting clock is the 10 kHz slow oscillator through a divider.
// - Time-out wakes the system and requests an interrupt when enabled.
// - Reset watchdog issues a system reset after a delay unless cleared.
// - Run bit starts or halts the counter, general-purpose mode only.
// - Writing one to counter-clear zeroes the count; zero does nothing.
// - Counter-clear reads one while the clear is still pending.
// - Time-out flag set on overflow; software clears it.
// - Low-power-run bit picks counting in low power, general-purpose only.
// - Reset-cause flag set by watchdog reset, cleared by power-on or by a software write of zero.
// - Prescale field is all ones after power-on, kept through other resets.
// - Prescale codes give 1/1, 1/4, 1/8 up to 1/256.
// - Time-out comes after 64 prescaled slow clock periods.
// - Control writes need the timed access unlock before each write.
// - Reset watchdog waits 512 slow clocks for a clear before resetting.
// - Counter and prescaler cleared on low-power entry, wake-up and reset.
// - General-purpose counter keeps counting after the flag is set.
`timescale 1ns/1ps
module watchdog_timeout_timer #(
	parameter int SLOW_DIV = wdt_pkg::SLOW_OSC_DIV
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic por_resetn,
	input wire logic [7:0] factory_option_byte_watchdog,
	input wire logic idle_mode,
	input wire logic pdown_mode,
	input wire logic wd_irq_enable,
	input wire logic global_irq_enable,
	output logic wd_irq_req,
	output logic wd_wakeup,
	output logic wd_sys_reset,
	input wire logic [wdt_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [wdt_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import wdt_pkg::*;

	logic any_reset;
	logic [3:0] wd_mode_field_q;
	logic wd_run_q, wd_lowpower_run_q, wd_timeout_flag_q, wd_reset_cause_flag_q;
	logic clr_pend_q;
	logic [2:0] wd_prescale_sel_q;
	logic [5:0] count_q;
	logic lowpower, lowpower_q, lp_edge;
	logic gp_mode, cnt_en, cnt_clear, timeout;
	logic slow_tick, scaled_tick;
	logic delay_act_q;
	logic [8:0] delay_cnt_q;
	logic delay_fire;
	key_state_type key_state_q;
	logic wr_fire, rd_fire, wr_hit, ctrl_wr;
	logic [7:0] ctrl_rd;

	assign any_reset = !aresetn || !por_resetn;

	// ==========================================================
	// Mode latch and counting conditions
	// Mode captured only while a reset is held
	always_ff @(posedge aclk) begin
		if (any_reset) begin
			wd_mode_field_q <= factory_option_byte_watchdog[MODE_MSB:MODE_LSB];
		end
	end

	assign lowpower = idle_mode || pdown_mode;
	assign gp_mode = (wd_mode_field_q == MODE_GP);

	// Entry into and wake from low power both seen as a change
	always_ff @(posedge aclk) begin
		if (any_reset) begin
			lowpower_q <= 1'b0;
		end else begin
			lowpower_q <= lowpower;
		end
	end
	assign lp_edge = lowpower != lowpower_q;

	// Whether the counter may advance in the current mode
	always_comb begin
		if (gp_mode) begin
			cnt_en = wd_run_q && (!lowpower || wd_lowpower_run_q);
		end else if (wd_mode_field_q == MODE_STOP_LP) begin
			cnt_en = !lowpower;
		end else begin
			cnt_en = 1'b1;
		end
	end

	assign cnt_clear = any_reset || lp_edge || clr_pend_q;

	wdt_prescaler #(
		.SLOW_DIV(SLOW_DIV)
	) u_prescaler (
		.aclk(aclk),
		.aresetn(!any_reset),
		.clear(cnt_clear),
		.enable(cnt_en),
		.sel(wd_prescale_sel_q),
		.slow_tick(slow_tick),
		.scaled_tick(scaled_tick)
	);

	// ==========================================================
	// Time-out counter
	assign timeout = scaled_tick && !cnt_clear && (count_q == 6'(TIMEOUT_TICKS - 1));

	// Six bit counter wraps and keeps going after a time-out
	always_ff @(posedge aclk) begin
		if (cnt_clear) begin
			count_q <= 6'h00;
		end else if (scaled_tick) begin
			count_q <= count_q + 6'h01;
		end
	end

	// Reset delay window after a time-out in watchdog modes
	assign delay_fire = delay_act_q && slow_tick && (delay_cnt_q == 9'h000);
	always_ff @(posedge aclk) begin
		if (any_reset || gp_mode || clr_pend_q) begin
			delay_act_q <= 1'b0;
			delay_cnt_q <= 9'h000;
		end else if (timeout && !delay_act_q) begin
			delay_act_q <= 1'b1;
			delay_cnt_q <= 9'(RESET_DELAY_TICKS - 1);
		end else if (delay_act_q && slow_tick) begin
			if (delay_cnt_q == 9'h000) begin
				delay_act_q <= 1'b0;
			end else begin
				delay_cnt_q <= delay_cnt_q - 9'h001;
			end
		end
	end

	// ==========================================================
	// Event outputs
	always_ff @(posedge aclk) begin
		if (any_reset) begin
			wd_sys_reset <= 1'b0;
			wd_wakeup <= 1'b0;
			wd_irq_req <= 1'b0;
		end else begin
			wd_sys_reset <= delay_fire;
			wd_wakeup <= timeout && lowpower;
			wd_irq_req <= wd_timeout_flag_q && wd_irq_enable && global_irq_enable;
		end
	end

	// ==========================================================
	// Timed access unlock
	assign wr_hit = wr_fire && s_axi_wstrb[0];
	assign ctrl_wr = wr_hit && (s_axi_awaddr == CTRL_ADDR) && (key_state_q == KEY_OPEN);

	// Two key bytes in a row open one control write
	always_ff @(posedge aclk) begin
		if (any_reset) begin
			key_state_q <= KEY_IDLE;
		end else if (wr_hit) begin
			case (key_state_q)
				KEY_IDLE: begin
					if (s_axi_awaddr == KEY_ADDR && s_axi_wdata[7:0] == KEY_FIRST) begin
						key_state_q <= KEY_HALF;
					end
				end
				KEY_HALF: begin
					if (s_axi_awaddr == KEY_ADDR && s_axi_wdata[7:0] == KEY_SECOND) begin
						key_state_q <= KEY_OPEN;
					end else begin
						key_state_q <= KEY_IDLE;
					end
				end
				default: begin
					key_state_q <= KEY_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Control register fields
	// Run and low-power-run, cleared by every reset
	always_ff @(posedge aclk) begin
		if (any_reset) begin
			wd_run_q <= 1'b0;
			wd_lowpower_run_q <= 1'b0;
		end else if (ctrl_wr) begin
			wd_run_q <= s_axi_wdata[RUN_BIT];
			wd_lowpower_run_q <= s_axi_wdata[LPRUN_BIT];
		end
	end

	// Clear request stays visible for the cycle it takes
	always_ff @(posedge aclk) begin
		if (any_reset) begin
			clr_pend_q <= 1'b0;
		end else begin
			clr_pend_q <= ctrl_wr && s_axi_wdata[CLR_BIT];
		end
	end

	// Time-out flag, hardware set wins over a software clear
	always_ff @(posedge aclk) begin
		if (any_reset) begin
			wd_timeout_flag_q <= 1'b0;
		end else if (timeout) begin
			wd_timeout_flag_q <= 1'b1;
		end else if (ctrl_wr) begin
			wd_timeout_flag_q <= s_axi_wdata[FLAG_BIT];
		end
	end

	// Reset-cause flag and prescale only follow power-on reset
	always_ff @(posedge aclk) begin
		if (!por_resetn) begin
			wd_reset_cause_flag_q <= 1'b0;
			wd_prescale_sel_q <= PRESCALE_RESET;
		end else begin
			if (delay_fire) begin
				wd_reset_cause_flag_q <= 1'b1;
			end else if (ctrl_wr) begin
				wd_reset_cause_flag_q <= s_axi_wdata[CAUSE_BIT];
			end
			if (ctrl_wr) begin
				wd_prescale_sel_q <= s_axi_wdata[PSEL_MSB:0];
			end
		end
	end

	assign ctrl_rd = {wd_run_q, clr_pend_q, wd_timeout_flag_q, wd_lowpower_run_q,
		wd_reset_cause_flag_q, wd_prescale_sel_q};

	// ==========================================================
	// AXI4-Lite write channel
	assign wr_fire = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
	always_ff @(posedge aclk) begin
		if (any_reset) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (s_axi_awaddr == CTRL_ADDR || s_axi_awaddr == KEY_ADDR) ?
					RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// AXI4-Lite read channel
	assign rd_fire = s_axi_arready && s_axi_arvalid;
	always_ff @(posedge aclk) begin
		if (any_reset) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= RESP_OKAY;
				case (s_axi_araddr)
					CTRL_ADDR: s_axi_rdata <= {24'h000000, ctrl_rd};
					MODE_ADDR: s_axi_rdata <= {28'h0000000, wd_mode_field_q};
					KEY_ADDR: s_axi_rdata <= 32'h00000000;
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Checks
	chk_timeout_flag: assert property (@(posedge aclk) disable iff (any_reset)
		timeout |=> wd_timeout_flag_q)
		else $error("time-out did not set the flag");

	chk_clear_count: assert property (@(posedge aclk) disable iff (any_reset)
		(ctrl_wr && s_axi_wdata[CLR_BIT]) |=> clr_pend_q ##1 (count_q == 6'h00 && !clr_pend_q))
		else $error("counter clear did not complete in two cycles");

	chk_halt_stable: assert property (@(posedge aclk) disable iff (any_reset)
		(!cnt_en && !cnt_clear && !scaled_tick) |=> (!scaled_tick && $stable(count_q)))
		else $error("counter moved while halted");

	chk_gp_no_reset: assert property (@(posedge aclk) disable iff (any_reset)
		gp_mode |-> (!delay_act_q && !wd_sys_reset))
		else $error("reset path active in general-purpose mode");

	chk_stop_lowpower: assert property (@(posedge aclk) disable iff (any_reset)
		(wd_mode_field_q == MODE_STOP_LP && lowpower) |-> !cnt_en ##1 !scaled_tick)
		else $error("counting enabled in low power for mode 0101");

	chk_fire_cause: assert property (@(posedge aclk) disable iff (any_reset)
		delay_fire |=> (wd_sys_reset && wd_reset_cause_flag_q))
		else $error("watchdog reset without cause flag");

	chk_por_prescale: assert property (@(posedge aclk) disable iff (1'b0)
		!por_resetn |=> (wd_prescale_sel_q == PRESCALE_RESET && !wd_reset_cause_flag_q))
		else $error("power-on reset did not restore prescale and cause");

	chk_mode_held: assert property (@(posedge aclk) disable iff (any_reset)
		1'b1 |=> $stable(wd_mode_field_q))
		else $error("mode field changed outside reset");

	chk_delay_start: assert property (@(posedge aclk) disable iff (any_reset)
		(timeout && !delay_act_q && !gp_mode && !clr_pend_q) |=>
		(delay_act_q && delay_cnt_q == 9'h1FF))
		else $error("reset delay not armed with 512 ticks");

endmodule // watchdog_timeout_timer

// file: watchdog_timeout_timer_test.sv
// Self-checking testbench for the watchdog timeout timer
`timescale 1ns/1ps
module watchdog_timeout_timer_test;
	import wdt_pkg::*;
	localparam int DIV = 4;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic por_resetn = 1'b0;
	logic [7:0] factory_option_byte_watchdog = 8'hFF;
	logic idle_mode = 1'b0;
	logic pdown_mode = 1'b0;
	logic wd_irq_enable = 1'b1;
	logic global_irq_enable = 1'b1;
	logic wd_irq_req, wd_wakeup, wd_sys_reset;
	logic [ADDR_W-1:0] s_axi_awaddr = 12'h000;
	logic [ADDR_W-1:0] s_axi_araddr = 12'h000;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	int err_total = 0;
	int samples_checked = 0;
	int seed = 13424;
	int rst_cnt = 0;

	// ==========================================================
	// Clock, design and event monitor
	always #2.5 aclk = ~aclk;

	watchdog_timeout_timer #(.SLOW_DIV(DIV)) i_watchdog_timeout_timer (
		.aclk, .aresetn, .por_resetn, .factory_option_byte_watchdog, .idle_mode, .pdown_mode,
		.wd_irq_enable, .global_irq_enable, .wd_irq_req, .wd_wakeup, .wd_sys_reset,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready
	);

	// Count system reset requests
	always @(posedge aclk) begin
		if (wd_sys_reset === 1'b1) begin
			rst_cnt <= rst_cnt + 1;
		end
	end

	// ==========================================================
	// Compare and verdict
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Cycle count within a tolerance of the model figure
	task automatic chk_rng(input string name, input int got, input int exp, input int tol);
		samples_checked++;
		if (got < exp - tol || got > exp + tol) begin
			err_total++;
			$display("[FAIL] %s expected %0d seen %0d", name, exp, got);
		end
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ==========================================================
	// AXI4-Lite master tasks
	task automatic axw(input logic [ADDR_W-1:0] a, input logic [7:0] d, output logic [1:0] r);
		int n;
		bit aw;
		bit w;
		n = 0;
		aw = 0;
		w = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'($random(seed)), d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw && w) && n < 100) begin
			@(posedge aclk);
			n++;
			if (s_axi_awready === 1'b1) begin
				aw = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready === 1'b1) begin
				w = 1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (s_axi_bvalid !== 1'b1 && n < 100) begin
			@(posedge aclk);
			n++;
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n >= 100) begin
			chk("write handshake", 32'h0, 32'h1);
		end
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] v, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (s_axi_arready !== 1'b1 && n < 100) begin
			@(posedge aclk);
			n++;
		end
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1 && n < 100) begin
			@(posedge aclk);
			n++;
		end
		v = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n >= 100) begin
			chk("read handshake", 32'h0, 32'h1);
		end
	endtask

	// Unlocked control write
	task automatic wctl(input logic [7:0] d);
		logic [1:0] r;
		axw(KEY_ADDR, KEY_FIRST, r);
		axw(KEY_ADDR, KEY_SECOND, r);
		axw(CTRL_ADDR, d, r);
	endtask

	// Cycles until wakeup (0), irq (1) or system reset (2) is seen
	task automatic wait_ev(input int sel, input int lim, output int t);
		t = 0;
		do begin
			@(posedge aclk);
			t++;
		end while (t < lim && !(sel == 0 ? wd_wakeup === 1'b1 :
			sel == 1 ? wd_irq_req === 1'b1 : wd_sys_reset === 1'b1));
	endtask

	task automatic pulse_reset(input bit por);
		aresetn <= 1'b0;
		por_resetn <= !por;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		por_resetn <= 1'b1;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		logic [31:0] v;
		logic [1:0] r;
		int t;
		int ps;
		int sc;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		por_resetn <= 1'b1;
		rd(CTRL_ADDR, v, r);
		chk("ctrl after power-on", 32'h07, v);
		rd(MODE_ADDR, v, r);
		chk("mode readback", 32'(MODE_GP), v);
		rd(12'h000, v, r);
		chk("unmapped read resp", 32'(RESP_SLVERR), 32'(r));
		axw(CTRL_ADDR, 8'h80, r);
		chk("locked write resp", 32'(RESP_OKAY), 32'(r));
		rd(CTRL_ADDR, v, r);
		chk("locked write", 32'h07, v);
		ps = $random(seed) & 1;
		sc = ps ? 4 : 1;
		// General-purpose timer counting through idle
		idle_mode <= 1'b1;
		wctl(8'h90 | 8'(ps));
		wait_ev(0, 64 * sc * DIV + 100, t);
		chk_rng("wakeup delay", t, 64 * sc * DIV, sc * DIV + 8);
		idle_mode <= 1'b0;
		rd(CTRL_ADDR, v, r);
		chk("flag set", 32'hB0 | ps, v);
		chk("irq raised", 32'h1, 32'(wd_irq_req));
		wd_irq_enable <= 1'b0;
		repeat (2) @(posedge aclk);
		chk("irq masked", 32'h0, 32'(wd_irq_req));
		wd_irq_enable <= 1'b1;
		wctl(8'h90 | 8'(ps));
		rd(CTRL_ADDR, v, r);
		chk("flag cleared", 32'h90 | ps, v);
		wait_ev(1, 64 * sc * DIV + 100, t);
		chk_rng("next interval", t, 64 * sc * DIV, sc * DIV + 40);
		wctl(8'h00 | 8'(ps));
		repeat (64 * sc * DIV + 50) @(posedge aclk);
		rd(CTRL_ADDR, v, r);
		chk("halted", 32'(ps), v);
		chk("irq low", 32'h0, 32'(wd_irq_req));
		chk("no reset in gp", 32'h0, 32'(rst_cnt));
		// Reset watchdog: feeding keeps the system alive
		factory_option_byte_watchdog <= 8'h00;
		pulse_reset(0);
		rd(CTRL_ADDR, v, r);
		chk("prescale kept", 32'(ps), v);
		repeat (20) begin
			wctl(8'h40 | 8'(ps));
			repeat (200) @(posedge aclk);
		end
		chk("fed no reset", 32'h0, 32'(rst_cnt));
		// Idle entry clears the count, which keeps running in this mode
		idle_mode <= 1'b1;
		wait_ev(2, 64 * sc * DIV + 512 * DIV + 200, t);
		chk_rng("reset delay", t, 64 * sc * DIV + 512 * DIV, sc * DIV + 40);
		idle_mode <= 1'b0;
		pulse_reset(0);
		rd(CTRL_ADDR, v, r);
		chk("cause set", 32'h08 | ps, v);
		pulse_reset(1);
		rd(CTRL_ADDR, v, r);
		chk("cause cleared", 32'h07, v);
		// Mode that halts in power-down
		factory_option_byte_watchdog <= 8'h5F;
		pulse_reset(1);
		wctl(8'h00);
		pdown_mode <= 1'b1;
		repeat (64 * DIV + 512 * DIV + 100) @(posedge aclk);
		chk("halted in power-down", 32'h1, 32'(rst_cnt));
		pdown_mode <= 1'b0;
		wait_ev(2, 64 * DIV + 512 * DIV + 200, t);
		chk("runs after wake", 32'h1, 32'(wd_sys_reset));
		// Software examines and then clears the reset cause
		pulse_reset(0);
		rd(CTRL_ADDR, v, r);
		chk("cause after reset", 32'h08, v);
		wctl(8'h00);
		rd(CTRL_ADDR, v, r);
		chk("cause cleared by software", 32'h00, v);
		give_verdict();
	end

	// Hang guard
	initial begin
		repeat (60000) @(posedge aclk);
		err_total++;
		give_verdict();
	end
endmodule // watchdog_timeout_timer_test
